/* design/phy_mac_port.sv */
// mac-facing nibble/serial data port of a 10/100 phy, with its rx fifo
// assumes the line coder sits on the core side in the clk domain; all mac
// and strap pins are asynchronous and are synchronised here
//
// Function
// - drive free-running transmit clock to mac
// - transmit enable marks valid transmit nibble
// - receive clock 25 mhz fast, 2.5 slow
// - collision output high on medium collision
// - carrier sense high unless medium idle
// - receive valid spans received nibbles, sampled rising
// - four receive lines change with receive clock
// - receive error high on decode error
// - management clock accepted with no phase relation
// - management data pin shared, released when idle
// - serial mode: 10 mb/s on bit zero
// - serial mode uses seven signals only; the port here also drives receive valid and receive error in serial mode
// - serial receive clock recovered from received stream
// - serial transmit clock generated by device
// - all interface clocks from one reference
// - strap high selects nibble, else serial
// - isolate disconnects data and management pins
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// flop-based fifo with valid/ready on both sides
// ------------------------------------------------------------------
module nibble_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             push;
	logic             pop;

	// full when pointers differ only in the wrap bit
	assign in_ready  = !((wr_q[AW] != rd_q[AW]) &&
		(wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid = (wr_q != rd_q);
	assign out_data  = mem_q[rd_q[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule // nibble_fifo

// ------------------------------------------------------------------
// port top
// ------------------------------------------------------------------
module phy_mac_port (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// mac data pins
	output logic                          mac_txc,
	input  wire logic                     mac_txen,
	input  wire logic [3:0]               mac_txd,
	output logic                          mac_rxc,
	output logic [3:0]                    mac_rxd,
	output logic                          mac_rxdv,
	output logic                          mac_rxer,
	output logic                          mac_crs,
	output logic                          mac_col,
	output logic                          mac_port_oe,
	// management pins
	input  wire logic                     mdc,
	input  wire logic                     mdio_i,
	output logic                          mdio_o,
	output logic                          mdio_oe,
	// configuration pins
	input  wire logic                     interface_select_strap,
	input  wire logic                     speed_100,
	input  wire logic                     isolate,
	// core receive side
	input  wire logic                     rx_in_valid,
	output logic                          rx_in_ready,
	input  wire phy_port_pkg::rx_word_t   rx_in,
	input  wire logic                     carrier_in,
	input  wire logic                     collision_in,
	// core transmit side
	output phy_port_pkg::tx_word_t        tx_out,
	output logic                          tx_stb,
	// core management side
	output logic                          mgmt_bit,
	output logic                          mgmt_stb,
	input  wire logic                     mgmt_drive,
	input  wire logic                     mgmt_out,
	// status
	output phy_port_pkg::link_mode_t      link_mode
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [phy_port_pkg::PIN_W-1:0]  pin_s1_q;
	logic [phy_port_pkg::PIN_W-1:0]  pin_s2_q;
	logic                            mdc_d1_q;
	logic [1:0]                      init_q;
	logic                            strap_q;
	logic                            iso;
	phy_port_pkg::link_mode_t        mode_q;
	logic [phy_port_pkg::DIV_W-1:0]  tx_cnt_q;
	logic [phy_port_pkg::DIV_W-1:0]  rx_cnt_q;
	logic                            txc_q;
	logic                            rxc_q;
	logic                            tx_rise;
	logic                            rx_fall;
	logic                            rx_restart;
	logic                            carrier_d1_q;
	logic [1:0]                      rx_idx_q;
	logic [1:0]                      tx_idx_q;
	logic [3:0]                      rx_sh_q;
	logic [3:0]                      tx_sh_q;
	logic [3:0]                      rxd_q;
	logic                            rxdv_q;
	logic                            rxer_q;
	logic                            crs_q;
	logic                            col_q;
	phy_port_pkg::tx_word_t          tx_q;
	logic                            tx_stb_q;
	logic                            mgmt_bit_q;
	logic                            mgmt_stb_q;
	logic                            mdio_o_q;
	logic                            mdio_oe_q;
	logic                            mdc_rise;
	logic                            mdc_fall;
	logic                            fifo_valid;
	logic                            fifo_pop;
	phy_port_pkg::rx_word_t          fifo_word;

	// half-period reload for the current mode
	function automatic logic [phy_port_pkg::DIV_W-1:0] reload_of(
		input phy_port_pkg::link_mode_t m);
		case (m)
			phy_port_pkg::MODE_FAST: reload_of = phy_port_pkg::RELOAD_FAST;
			phy_port_pkg::MODE_SER:  reload_of = phy_port_pkg::RELOAD_SER;
			default:                 reload_of = phy_port_pkg::RELOAD_SLOW;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers and configuration
	// ----------------------------------------------------------------
	// two flops on every asynchronous pin
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_s1_q <= phy_port_pkg::RST_PINS;
			pin_s2_q <= phy_port_pkg::RST_PINS;
			mdc_d1_q <= 1'b0;
		end else begin
			pin_s1_q <= {isolate, speed_100, interface_select_strap,
				mdio_i, mdc, mac_txd, mac_txen};
			pin_s2_q <= pin_s1_q;
			mdc_d1_q <= pin_s2_q[phy_port_pkg::PIN_MDC];
		end
	end

	assign iso = pin_s2_q[phy_port_pkg::PIN_ISO];

	// strap caught once, after the synchroniser has filled
	always_ff @(posedge clk) begin
		if (rst) begin
			init_q  <= 2'h0;
			strap_q <= 1'b0;
		end else begin
			if (init_q != 2'h3) begin
				init_q <= init_q + 1'b1;
			end
			// only the second stage is read: the first may be metastable
			if (init_q == 2'h2) begin
				strap_q <= pin_s2_q[phy_port_pkg::PIN_STRAP];
			end
		end
	end

	// mode: nibble at strap high, else 10 mb/s serial
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= phy_port_pkg::MODE_SER;
		end else if (!strap_q) begin
			mode_q <= phy_port_pkg::MODE_SER;
		end else if (pin_s2_q[phy_port_pkg::PIN_SPEED]) begin
			mode_q <= phy_port_pkg::MODE_FAST;
		end else begin
			mode_q <= phy_port_pkg::MODE_SLOW;
		end
	end

	// ----------------------------------------------------------------
	// interface clock generators
	// ----------------------------------------------------------------
	assign tx_rise    = (tx_cnt_q == phy_port_pkg::RST_CNT) && !txc_q;
	assign rx_fall    = (rx_cnt_q == phy_port_pkg::RST_CNT) && rxc_q;
	assign rx_restart = (mode_q == phy_port_pkg::MODE_SER) &&
		carrier_in && !carrier_d1_q;

	// free-running transmit clock from the reference divider
	always_ff @(posedge clk) begin
		if (rst || iso) begin
			tx_cnt_q <= phy_port_pkg::RST_CNT;
			txc_q    <= 1'b0;
		end else if (tx_cnt_q == phy_port_pkg::RST_CNT) begin
			tx_cnt_q <= reload_of(mode_q);
			txc_q    <= !txc_q;
		end else begin
			tx_cnt_q <= tx_cnt_q - 1'b1;
		end
	end

	// receive clock; in serial mode re-phased to the incoming stream
	always_ff @(posedge clk) begin
		if (rst || iso) begin
			rx_cnt_q     <= phy_port_pkg::RST_CNT;
			rxc_q        <= 1'b0;
			carrier_d1_q <= 1'b0;
		end else begin
			carrier_d1_q <= carrier_in;
			if (rx_restart) begin
				rx_cnt_q <= reload_of(mode_q);
				rxc_q    <= 1'b0;
			end else if (rx_cnt_q == phy_port_pkg::RST_CNT) begin
				rx_cnt_q <= reload_of(mode_q);
				rxc_q    <= !rxc_q;
			end else begin
				rx_cnt_q <= rx_cnt_q - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// receive path
	// ----------------------------------------------------------------
	nibble_fifo #(
		.WIDTH ($bits(phy_port_pkg::rx_word_t)),
		.DEPTH (phy_port_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.in_data   (rx_in),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_word)
	);

	// a word leaves only on a falling receive edge at a nibble start
	assign fifo_pop = rx_fall && (rx_idx_q == phy_port_pkg::RST_IDX) &&
		fifo_valid && !iso;

	// outputs change on falling edge so the mac samples them rising
	always_ff @(posedge clk) begin
		if (rst || iso) begin
			rxd_q    <= 4'h0;
			rxdv_q   <= 1'b0;
			rxer_q   <= 1'b0;
			rx_sh_q  <= 4'h0;
			rx_idx_q <= phy_port_pkg::RST_IDX;
		end else if (rx_fall) begin
			if (rx_idx_q != phy_port_pkg::RST_IDX) begin
				rxd_q    <= {3'h0, rx_sh_q[rx_idx_q]};
				rx_idx_q <= rx_idx_q + 1'b1;
			end else if (fifo_pop) begin
				rxdv_q  <= 1'b1;
				rxer_q  <= fifo_word.err;
				rx_sh_q <= fifo_word.nib;
				if (mode_q == phy_port_pkg::MODE_SER) begin
					rxd_q    <= {3'h0, fifo_word.nib[0]};
					rx_idx_q <= 2'h1;
				end else begin
					rxd_q <= fifo_word.nib;
				end
			end else begin
				rxdv_q <= 1'b0;
				rxer_q <= 1'b0;
				rxd_q  <= 4'h0;
			end
		end
	end

	// medium status
	always_ff @(posedge clk) begin
		if (rst || iso) begin
			crs_q <= 1'b0;
			col_q <= 1'b0;
		end else begin
			crs_q <= carrier_in;
			col_q <= collision_in;
		end
	end

	// ----------------------------------------------------------------
	// transmit path
	// ----------------------------------------------------------------
	// sampled at the rising edge: the synchronised copy shows the pins
	// as they stood two clk cycles earlier, mid-way through the previous period only at the fast rate
	always_ff @(posedge clk) begin
		if (rst || iso) begin
			tx_q     <= '0;
			tx_stb_q <= 1'b0;
			tx_sh_q  <= 4'h0;
			tx_idx_q <= phy_port_pkg::RST_IDX;
		end else begin
			tx_stb_q <= 1'b0;
			if (tx_rise && pin_s2_q[phy_port_pkg::PIN_TXEN]) begin
				if (mode_q != phy_port_pkg::MODE_SER) begin
					tx_q     <= {1'b1, pin_s2_q[phy_port_pkg::PIN_TXD +: 4]};
					tx_stb_q <= 1'b1;
				end else begin
					tx_sh_q[tx_idx_q] <= pin_s2_q[phy_port_pkg::PIN_TXD];
					tx_idx_q <= tx_idx_q + 1'b1;
					if (tx_idx_q == 2'h3) begin
						tx_q <= {1'b1, pin_s2_q[phy_port_pkg::PIN_TXD],
							tx_sh_q[2:0]};
						tx_stb_q <= 1'b1;
					end
				end
			end else if (tx_rise) begin
				tx_q.en  <= 1'b0;
				tx_idx_q <= phy_port_pkg::RST_IDX;
			end
		end
	end

	// ----------------------------------------------------------------
	// management pins
	// ----------------------------------------------------------------
	assign mdc_rise = pin_s2_q[phy_port_pkg::PIN_MDC] && !mdc_d1_q;
	assign mdc_fall = !pin_s2_q[phy_port_pkg::PIN_MDC] && mdc_d1_q;

	// sample on mdc rising, drive on mdc falling, release when idle
	always_ff @(posedge clk) begin
		if (rst || iso) begin
			mgmt_bit_q <= 1'b0;
			mgmt_stb_q <= 1'b0;
			mdio_o_q   <= 1'b0;
			mdio_oe_q  <= 1'b0;
		end else begin
			mgmt_stb_q <= mdc_rise;
			if (mdc_rise) begin
				mgmt_bit_q <= pin_s2_q[phy_port_pkg::PIN_MDIO];
			end
			if (mdc_fall) begin
				mdio_o_q  <= mgmt_out;
				mdio_oe_q <= mgmt_drive;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign mac_txc     = txc_q;
	assign mac_rxc     = rxc_q;
	assign mac_rxd     = rxd_q;
	assign mac_rxdv    = rxdv_q;
	assign mac_rxer    = rxer_q;
	assign mac_crs     = crs_q;
	assign mac_col     = col_q;
	assign mac_port_oe = !iso;
	assign mdio_o      = mdio_o_q;
	assign mdio_oe     = mdio_oe_q;
	assign tx_out      = tx_q;
	assign tx_stb      = tx_stb_q;
	assign mgmt_bit    = mgmt_bit_q;
	assign mgmt_stb    = mgmt_stb_q;
	assign link_mode   = mode_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_ser_pop;
		fifo_pop && (mode_q == phy_port_pkg::MODE_SER);
	endsequence

	a_txc_fast_half: assert property (@(posedge clk) disable iff (rst || iso)
		$rose(txc_q) && (mode_q == phy_port_pkg::MODE_FAST) && $stable(mode_q)
		|-> ##2 $fell(txc_q))
		else $error("transmit clock half period wrong at fast rate");
	a_rxc_slow_half: assert property (@(posedge clk) disable iff (rst || iso)
		$rose(rxc_q) && (mode_q == phy_port_pkg::MODE_SLOW) && $stable(mode_q)
		|-> ##20 $fell(rxc_q))
		else $error("receive clock half period wrong at slow rate");
	a_rxdv_on_pop: assert property (@(posedge clk) disable iff (rst || iso)
		fifo_pop |=> rxdv_q && (rxer_q == $past(fifo_word.err)))
		else $error("receive valid or error not set with popped nibble");
	a_rxdv_end: assert property (@(posedge clk) disable iff (rst || iso)
		rx_fall && !fifo_valid && (rx_idx_q == phy_port_pkg::RST_IDX)
		|=> !rxdv_q)
		else $error("receive valid held after packet end");
	a_ser_bit_order: assert property (@(posedge clk) disable iff (rst || iso)
		s_ser_pop |=> (rxd_q == {3'h0, rx_sh_q[0]}) && (rx_idx_q == 2'h1))
		else $error("serial receive did not start at bit zero");
	a_col_follow: assert property (@(posedge clk) disable iff (rst || iso)
		1'b1 |=> (col_q == $past(collision_in)))
		else $error("collision not reported");
	a_crs_follow: assert property (@(posedge clk) disable iff (rst || iso)
		1'b1 |=> (crs_q == $past(carrier_in)))
		else $error("carrier sense high on idle medium");
	a_tx_capture: assert property (@(posedge clk) disable iff (rst || iso)
		tx_rise && pin_s2_q[phy_port_pkg::PIN_TXEN] &&
		(mode_q != phy_port_pkg::MODE_SER) |=> tx_stb && tx_out.en)
		else $error("transmit nibble not taken while enable high");
	a_rx_rephase: assert property (@(posedge clk) disable iff (rst || iso)
		rx_restart |=> !rxc_q ##1 !rxc_q)
		else $error("serial receive clock not re-phased at carrier");
	a_iso_quiet: assert property (@(posedge clk) disable iff (rst)
		iso |-> !mac_port_oe ##1 (!mdio_oe && !mac_rxdv && !mac_txc))
		else $error("isolate did not release the pins");
endmodule // phy_mac_port

`default_nettype wire

/* shared/phy_port_pkg.sv */
// constants, carriers and modes for the mac-facing data port of the phy
// assumes a 100 mhz core clock; interface clocks are derived from it
package phy_port_pkg;

	// ----------------------------------------------------------------
	// clocking
	// ----------------------------------------------------------------
	localparam int CLK_HZ       = 100_000_000; // core clock
	localparam int REF_HZ       = 25_000_000;  // reference the two nibble rates come from
	localparam int RATE_FAST_HZ = REF_HZ;      // nibble clock at 100 mb/s
	localparam int RATE_SLOW_HZ = REF_HZ / 10; // nibble clock at 10 mb/s
	localparam int RATE_SER_HZ  = 10_000_000;  // bit clock in serial mode
	localparam int DIV_W        = 5;
	localparam logic [DIV_W-1:0] RELOAD_FAST =
		DIV_W'(CLK_HZ / (2 * RATE_FAST_HZ) - 1);
	localparam logic [DIV_W-1:0] RELOAD_SLOW =
		DIV_W'(CLK_HZ / (2 * RATE_SLOW_HZ) - 1);
	localparam logic [DIV_W-1:0] RELOAD_SER =
		DIV_W'(CLK_HZ / (2 * RATE_SER_HZ) - 1);

	// ----------------------------------------------------------------
	// sizes, pin vector layout and reset values
	// ----------------------------------------------------------------
	localparam int NIB_W      = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int PIN_TXEN   = 0;
	localparam int PIN_TXD    = 1; // four bits from here
	localparam int PIN_MDC    = 5;
	localparam int PIN_MDIO   = 6;
	localparam int PIN_STRAP  = 7;
	localparam int PIN_SPEED  = 8;
	localparam int PIN_ISO    = 9;
	localparam int PIN_W      = 10;
	localparam logic [PIN_W-1:0] RST_PINS = 10'h000;
	localparam logic [DIV_W-1:0] RST_CNT  = 5'h00;
	localparam logic [1:0]       RST_IDX  = 2'h0;

	// ----------------------------------------------------------------
	// carriers and modes
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             err; // decoder found a bad code group
		logic [NIB_W-1:0] nib;
	} rx_word_t;

	typedef struct packed {
		logic             en;
		logic [NIB_W-1:0] nib;
	} tx_word_t;

	typedef enum logic [2:0] {
		MODE_FAST = 3'b001,
		MODE_SLOW = 3'b010,
		MODE_SER  = 3'b100
	} link_mode_t;

endpackage

/* verif/mac_model.sv */
// behavioural mac: sends nibble frames timed by the phy transmit clock
// assumes txc comes from the device; the bench asks for a frame by
// toggling req with base and len already set
`timescale 1ns/1ps
`default_nettype none
module mac_model (
	// clock from the phy
	input  wire logic       txc,
	// frame request from the bench
	input  wire logic       req,
	input  wire logic [3:0] base,
	input  wire logic [4:0] len,
	// transmit pins
	output logic            txen,
	output logic [3:0]      txd
);
	logic       ack  = 1'b0;
	logic [4:0] left = 5'h0;
	logic [3:0] nib  = 4'h0;

	initial begin
		txen = 1'b0;
		txd  = 4'h5;
	end

	// launch just after each rising transmit clock edge
	always @(posedge txc) begin
		#1;
		if (left == 5'h0 && req !== ack) begin
			left = len;
			nib  = base;
			ack  = req;
		end
		if (left != 5'h0) begin
			txen = 1'b1;
			txd  = nib;
			nib  = nib + 4'h1;
			left = left - 5'h1;
		end else begin
			txen = 1'b0;
			txd  = ~txd; // idle lines never hold the last value
		end
	end
endmodule // mac_model
`default_nettype wire

/* verif/phy_mac_port_tb.sv */
// self-checking bench for the mac-facing data port
// assumes phy_port_pkg, the design and mac_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module phy_mac_port_tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int FAST = phy_port_pkg::CLK_HZ / phy_port_pkg::RATE_FAST_HZ;
	localparam int SLOW = phy_port_pkg::CLK_HZ / phy_port_pkg::RATE_SLOW_HZ;
	localparam int SER  = phy_port_pkg::CLK_HZ / phy_port_pkg::RATE_SER_HZ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mac_txc, mac_txen, mac_rxc, mac_rxdv, mac_rxer, mac_crs, mac_col;
	logic [3:0] mac_txd, mac_rxd, base;
	logic [4:0] len;
	logic mac_port_oe, mdc, mdio_i, mdio_o, mdio_oe, tb_mdio, tb_oe;
	logic strap, speed, iso, rx_in_valid, rx_in_ready, carrier_in;
	logic collision_in, tx_stb, mgmt_bit, mgmt_stb, mgmt_drive, mgmt_out;
	logic req = 1'b0;
	logic ser = 1'b0;
	phy_port_pkg::rx_word_t   rx_in;
	phy_port_pkg::tx_word_t   tx_out;
	phy_port_pkg::link_mode_t link_mode;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h0000_8da2;
	logic [4:0] rxq[$];
	logic [3:0] txq[$];
	logic       mq[$];
	logic [3:0] sbits = 4'h0;
	int         scnt  = 0;

	// mdio has a pull-up when nobody drives it
	assign mdio_i = mdio_oe ? mdio_o : (tb_oe ? tb_mdio : 1'b1);

	initial forever #5 clk = ~clk;

	// ----------------------------------------------------------------
	// design and partner
	// ----------------------------------------------------------------
	phy_mac_port i_phy_mac_port (.clk(clk), .rst(rst), .mac_txc(mac_txc),
		.mac_txen(mac_txen), .mac_txd(mac_txd), .mac_rxc(mac_rxc),
		.mac_rxd(mac_rxd), .mac_rxdv(mac_rxdv), .mac_rxer(mac_rxer),
		.mac_crs(mac_crs), .mac_col(mac_col), .mac_port_oe(mac_port_oe),
		.mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
		.interface_select_strap(strap), .speed_100(speed), .isolate(iso),
		.rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in(rx_in),
		.carrier_in(carrier_in), .collision_in(collision_in),
		.tx_out(tx_out), .tx_stb(tx_stb), .mgmt_bit(mgmt_bit),
		.mgmt_stb(mgmt_stb), .mgmt_drive(mgmt_drive), .mgmt_out(mgmt_out),
		.link_mode(link_mode));
	mac_model i_mac_model (.txc(mac_txc), .req(req), .base(base),
		.len(len), .txen(mac_txen), .txd(mac_txd));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task check(input string what, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task give_verdict();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task reset_dut();
		rst = 1'b1;
		tick(5);
		rst = 1'b0;
		tick(8);
	endtask

	// clk cycles between two rising edges of txc (sel 0) or rxc (sel 1)
	task period(input logic sel, input int exp);
		int c, n, k;
		logic p, v;
		c = 0;
		n = 0;
		p = 1'b1;
		for (k = 0; k < 200 && n < 2; k++) begin
			tick(1);
			v = sel ? mac_rxc : mac_txc;
			if (n > 0) c++;
			if (v === 1'b1 && p === 1'b0) n++;
			p = v;
		end
		check("clk_period", 8'(c), 8'(exp));
	endtask

	// push words; fill stops at the first refusal
	task rx_burst(input int n, input bit fill);
		int k;
		logic [4:0] w;
		logic r;
		for (k = 0; k < n; k++) begin
			w = 5'(rnd());
			rx_in = phy_port_pkg::rx_word_t'(w);
			rx_in_valid = 1'b1;
			@(negedge clk);
			r = rx_in_ready;
			if (r === 1'b1) rxq.push_back(w);
			tick(1);
			if (r !== 1'b1 && fill) break;
			if (r !== 1'b1) k--;
		end
		if (fill) check("rx_refused", 8'(r), 8'h00);
		rx_in_valid = 1'b0;
		for (k = 0; k < 900 && rxq.size() > 0; k++) tick(1);
		tick(3 * SLOW);
		check("rx_idle", 8'(mac_rxdv), 8'h00);
	endtask

	task tx_frame(input logic [3:0] b, input logic [4:0] n);
		int k;
		logic [3:0] t;
		logic [3:0] sn;
		base = b;
		len  = n;
		sn   = 4'h0;
		// serial mode packs four bit-0 beats, first beat into bit 0
		for (k = 0; k < n; k++) begin
			t = b + 4'(k);
			sn[k % 4] = t[0];
			if (!ser) txq.push_back(t);
			else if (k % 4 == 3) txq.push_back(sn);
		end
		req = ~req;
		for (k = 0; k < 2000 && txq.size() > 0; k++) tick(1);
		check("tx_left", 8'(txq.size()), 8'h00);
	endtask

	task mdc_cycle(input logic b);
		tb_mdio = b;
		#62.5 mdc = 1'b1;
		#62.5 mdc = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// output watchers
	// ----------------------------------------------------------------
	always @(posedge mac_rxc)
		if (mac_rxdv === 1'b1 && !ser)
			check("rx_word", {3'h0, mac_rxer, mac_rxd},
				{3'h0, rxq.pop_front()});

	// serial receive bits gather lsb first
	always @(posedge mac_rxc)
		if (mac_rxdv === 1'b1 && ser) begin
			sbits = {mac_rxd[0], sbits[3:1]};
			scnt++;
		end

	always @(negedge clk)
		if (tx_stb === 1'b1 && tx_out.en === 1'b1)
			check("tx_nib", 8'(tx_out.nib), 8'(txq.pop_front()));

	always @(negedge clk)
		if (mgmt_stb === 1'b1 && mq.size() > 0)
			check("mgmt_bit", 8'(mgmt_bit), 8'(mq.pop_front()));

	initial begin
		#300us;
		error_cnt++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int k;
		int c;
		logic [1:0] v;
		logic [4:0] w;
		strap = 1'b1;
		speed = 1'b1;
		iso = 1'b0;
		rx_in_valid = 1'b0;
		rx_in = '0;
		carrier_in = 1'b0;
		collision_in = 1'b0;
		mgmt_drive = 1'b0;
		mgmt_out = 1'b0;
		mdc = 1'b0;
		tb_mdio = 1'b0;
		tb_oe = 1'b0;
		base = 4'h0;
		len = 5'h00;
		reset_dut();
		check("mode", 8'(link_mode), 8'(phy_port_pkg::MODE_FAST));
		check("port_oe", 8'(mac_port_oe), 8'h01);
		period(1'b0, FAST);
		period(1'b1, FAST);
		rx_burst(60, 1'b1);
		tx_frame(4'hd, 5'h07);
		// carrier and collision follow the core one clock later
		for (k = 0; k < 24; k++) begin
			v = 2'(rnd());
			carrier_in = v[1];
			collision_in = v[0];
			tick(1);
			check("crs_col", {6'h0, mac_crs, mac_col}, {6'h0, v});
		end
		carrier_in = 1'b0;
		collision_in = 1'b0;
		// management bits in, then the device takes the pin
		tb_oe = 1'b1;
		for (k = 0; k < 8; k++) begin
			v = 2'(rnd());
			mq.push_back(v[0]);
			mdc_cycle(v[0]);
		end
		tb_oe = 1'b0;
		mgmt_drive = 1'b1;
		mgmt_out = 1'b1;
		mdc_cycle(1'b0);
		tick(6);
		check("mdio_drive", {6'h0, mdio_oe, mdio_o}, 8'h03);
		// isolate drops every mac pin and the management drive
		iso = 1'b1;
		tick(4);
		check("iso_oe", {6'h0, mac_port_oe, mdio_oe}, 8'h00);
		c = 0;
		for (k = 0; k < 20; k++) begin
			tick(1);
			if (mac_txc !== 1'b0) c++;
		end
		check("iso_txc", 8'(c), 8'h00);
		iso = 1'b0;
		tick(4);
		mdc_cycle(1'b0);
		tick(6);
		check("mdio_back", {6'h0, mdio_oe, mdio_o}, 8'h03);
		mgmt_drive = 1'b0;
		mdc_cycle(1'b0);
		tick(6);
		check("mdio_free", 8'(mdio_oe), 8'h00);
		// 10 mb/s nibble mode
		speed = 1'b0;
		tick(8);
		check("mode", 8'(link_mode), 8'(phy_port_pkg::MODE_SLOW));
		period(1'b0, SLOW);
		period(1'b1, SLOW);
		rx_burst(4, 1'b0);
		tx_frame(4'h2, 5'h05);
		// serial mode after a fresh reset with the strap low
		strap = 1'b0;
		ser = 1'b1;
		reset_dut();
		check("mode", 8'(link_mode), 8'(phy_port_pkg::MODE_SER));
		period(1'b0, SER);
		carrier_in = 1'b1;
		period(1'b1, SER);
		w = 5'(rnd());
		rx_in = phy_port_pkg::rx_word_t'(w);
		rx_in_valid = 1'b1;
		tick(1);
		rx_in_valid = 1'b0;
		c = 0;
		for (k = 0; k < 60; k++) begin
			tick(1);
			if (mac_rxd[3:1] !== 3'h0) c++;
		end
		check("ser_rxd_hi", 8'(c), 8'h00);
		check("ser_bits", {4'h0, sbits}, {4'h0, w[3:0]});
		check("ser_count", 8'(scnt), 8'h04);
		tx_frame(4'h6, 5'h08);
		give_verdict();
	end
endmodule // phy_mac_port_tb
`default_nettype wire
